// File: logic/limit_pkg.sv
/*
  Constants shared by the limit compare and diagnostic flag block:
  register indices, field positions, reset values, threshold scaling.
  Assumes a serial port front end that turns frames into word strobes.
*/
package limit_pkg;
  // --------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------
  localparam logic [5:0] diag_index       = 6'h0b;
  localparam logic [5:0] shunt_over_index = 6'h0c;
  localparam logic [5:0] shunt_under_index = 6'h0d;
  localparam logic [5:0] bus_over_index   = 6'h0e;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] shunt_over_reset  = 16'h7fff;
  localparam logic [15:0] shunt_under_reset = 16'h8000;
  localparam logic [14:0] bus_over_reset    = 15'h7fff;

  // --------------------------------------------------------------
  // diagnostic field positions
  // --------------------------------------------------------------
  localparam int latch_bit     = 15;
  localparam int coulomb_bit   = 10;
  localparam int arith_bit     = 9;
  localparam int reserved_bit  = 8;
  localparam int temp_bit      = 7;
  localparam int shunt_ov_bit  = 6;
  localparam int shunt_un_bit  = 5;
  localparam int bus_ov_bit    = 4;
  localparam int bus_un_bit    = 3;
  localparam int power_bit     = 2;
  localparam int done_bit      = 1;
  localparam int checksum_bit  = 0;
  localparam int limit_flags   = 6;

  // --------------------------------------------------------------
  // threshold step sizes, nanovolts and millivolts
  // --------------------------------------------------------------
  localparam int    shunt_step_wide_nv   = 5000;
  localparam int    shunt_step_narrow_nv = 1250;
  localparam real   bus_step_mv          = 3.125;
  localparam int    accumulator_width    = 40;
endpackage

// File: logic/limit_flag.sv
/*
  One limit-violation flag with latched or transparent behaviour.
  Assumes the fault input is valid only while its update strobe is high.
*/
`timescale 1ns/1ps
module limit_flag
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic update,
  input  wire logic fault,
  input  wire logic latch_mode,
  input  wire logic read_clear,
  output logic      flag_q
);
  // ------------------------------------------------------------
  // flag state
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (!latch_mode)
    begin
      if (update)
        flag_q <= fault;
    end
    else if (update && fault)
      flag_q <= 1'b1;
    else if (read_clear)
      flag_q <= 1'b0;
  end

  property p_latch_hold;
    @(posedge clock) disable iff (rst)
      (latch_mode && flag_q && !read_clear) |=> flag_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost");

  property p_set_same;
    @(posedge clock) disable iff (rst)
      (update && fault) |=> flag_q;
  endproperty
  a_set_same: assert property (p_set_same) else $error("flag not set on fault");
endmodule

// File: logic/limit_compare_diag_flags.sv
/*
  Threshold registers, limit comparators and the diagnostic flag register.
  Assumes the serial port decodes frames into a word index with one-cycle
  read and write strobes, and the measurement core gives result strobes.
*/
`timescale 1ns/1ps
module limit_compare_diag_flags
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [5:0]  reg_index,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_q,
  input  wire logic        result_valid,
  input  wire logic [19:0] shunt_reading,
  input  wire logic [19:0] bus_reading,
  input  wire logic [15:0] temp_reading,
  input  wire logic [23:0] power_reading,
  input  wire logic [15:0] temp_limit,
  input  wire logic [15:0] power_limit,
  input  wire logic [14:0] bus_under_threshold,
  input  wire logic        input_range_select,
  input  wire logic        conversion_done,
  input  wire logic        conversion_start,
  input  wire logic        arith_overflow,
  input  wire logic        coulomb_wrap,
  input  wire logic        charge_read,
  input  wire logic        accumulator_clear,
  input  wire logic        checksum_fail,
  output logic             alert_latch_select_q,
  output logic             coulomb_overflow_flag_q,
  output logic             arith_overflow_flag_q,
  output logic             conversion_done_flag_q,
  output logic             trim_checksum_ok_q,
  output logic      [5:0]  limit_flags_q
);
  // ------------------------------------------------------------
  // threshold registers
  // ------------------------------------------------------------
  logic [15:0] shunt_over_threshold_q;
  logic [15:0] shunt_under_threshold_q;
  logic [14:0] bus_over_threshold_q;
  logic        diag_read;
  logic [5:0]  fault_vec;

  assign diag_read = reg_read && (reg_index == limit_pkg::diag_index);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      shunt_over_threshold_q <= limit_pkg::shunt_over_reset;
    else if (reg_write && reg_index == limit_pkg::shunt_over_index)
      shunt_over_threshold_q <= reg_wdata;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      shunt_under_threshold_q <= limit_pkg::shunt_under_reset;
    else if (reg_write && reg_index == limit_pkg::shunt_under_index)
      shunt_under_threshold_q <= reg_wdata;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bus_over_threshold_q <= limit_pkg::bus_over_reset;
    else if (reg_write && reg_index == limit_pkg::bus_over_index)
      bus_over_threshold_q <= reg_wdata[14:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      alert_latch_select_q <= 1'b0;
    else if (reg_write && reg_index == limit_pkg::diag_index)
      alert_latch_select_q <= reg_wdata[limit_pkg::latch_bit];
  end

  // ------------------------------------------------------------
  // comparators
  // ------------------------------------------------------------
  // one shunt or bus threshold step is 16 reading codes, one power step 256;
  // the range scales readings and thresholds alike, so no range term
  always_comb
  begin
    fault_vec[5] = $signed(temp_reading) > $signed(temp_limit);
    fault_vec[4] = $signed(shunt_reading[19:4]) > $signed(shunt_over_threshold_q);
    fault_vec[3] = $signed(shunt_reading[19:4]) < $signed(shunt_under_threshold_q);
    fault_vec[2] = bus_reading[19:4] > {1'b0, bus_over_threshold_q};
    fault_vec[1] = bus_reading[19:4] < {1'b0, bus_under_threshold};
    fault_vec[0] = power_reading[23:8] > power_limit;
  end

  // ------------------------------------------------------------
  // limit flags, order temp down to power
  // ------------------------------------------------------------
  // update with each result
  genvar g;
  generate
    for (g = 0; g < limit_pkg::limit_flags; g++)
    begin : g_flag
      limit_flag u_flag
      (
        .clock      (clock),
        .rst        (rst),
        .update     (result_valid),
        .fault      (fault_vec[g]),
        .latch_mode (alert_latch_select_q),
        .read_clear (diag_read),
        .flag_q     (limit_flags_q[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // set wins over accumulator read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      coulomb_overflow_flag_q <= 1'b0;
    else if (coulomb_wrap)
      coulomb_overflow_flag_q <= 1'b1;
    else if (charge_read)
      coulomb_overflow_flag_q <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      arith_overflow_flag_q <= 1'b0;
    else if (arith_overflow)
      arith_overflow_flag_q <= 1'b1;
    else if (conversion_start || accumulator_clear)
      arith_overflow_flag_q <= 1'b0;
  end

  // transparent mode holds until next start
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      conversion_done_flag_q <= 1'b0;
    else if (conversion_done)
      conversion_done_flag_q <= 1'b1;
    else if (alert_latch_select_q && (diag_read || conversion_start))
      conversion_done_flag_q <= 1'b0;
    else if (!alert_latch_select_q && conversion_start)
      conversion_done_flag_q <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      trim_checksum_ok_q <= 1'b1;
    else
      trim_checksum_ok_q <= !checksum_fail;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata_q <= 16'h0000;
    else if (reg_read)
    begin
      unique case (reg_index)
        limit_pkg::diag_index:
          reg_rdata_q <= {alert_latch_select_q, 4'h0, coulomb_overflow_flag_q,
                          arith_overflow_flag_q, 1'b0, limit_flags_q[5:0],
                          conversion_done_flag_q, trim_checksum_ok_q};
        limit_pkg::shunt_over_index:
          reg_rdata_q <= shunt_over_threshold_q;
        limit_pkg::shunt_under_index:
          reg_rdata_q <= shunt_under_threshold_q;
        limit_pkg::bus_over_index:
          reg_rdata_q <= {1'b0, bus_over_threshold_q};
        default:
          reg_rdata_q <= 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_coulomb;
    @(posedge clock) disable iff (rst)
      coulomb_wrap |=> coulomb_overflow_flag_q;
  endproperty
  a_coulomb: assert property (p_coulomb) else $error("coulomb flag not set");

  property p_arith_set;
    @(posedge clock) disable iff (rst)
      arith_overflow |=> arith_overflow_flag_q;
  endproperty
  a_arith_set: assert property (p_arith_set) else $error("arith flag not set");

  property p_arith_hold;
    @(posedge clock) disable iff (rst)
      (arith_overflow_flag_q && !conversion_start && !accumulator_clear) |=> arith_overflow_flag_q;
  endproperty
  a_arith_hold: assert property (p_arith_hold) else $error("arith flag dropped");

  property p_reserved;
    @(posedge clock) disable iff (rst)
      diag_read |=> reg_rdata_q[limit_pkg::reserved_bit] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_shunt_over;
    @(posedge clock) disable iff (rst)
      (result_valid && $signed(shunt_reading[19:4]) > $signed(shunt_over_threshold_q))
        |=> limit_flags_q[4];
  endproperty
  a_shunt_over: assert property (p_shunt_over) else $error("shunt over missed");

  property p_done;
    @(posedge clock) disable iff (rst)
      conversion_done |=> conversion_done_flag_q;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");

  property p_done_clear;
    @(posedge clock) disable iff (rst)
      (alert_latch_select_q && diag_read && !conversion_done) |=> !conversion_done_flag_q;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_checksum;
    @(posedge clock) disable iff (rst)
      checksum_fail |=> !trim_checksum_ok_q;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum status wrong");

  property p_bus_top;
    @(posedge clock) disable iff (rst)
      (reg_read && reg_index == limit_pkg::bus_over_index) |=> !reg_rdata_q[15];
  endproperty
  a_bus_top: assert property (p_bus_top) else $error("bus threshold bit 15 set");

  property p_coulomb_clear;
    @(posedge clock) disable iff (rst)
      (charge_read && !coulomb_wrap) |=> !coulomb_overflow_flag_q;
  endproperty
  a_coulomb_clear: assert property (p_coulomb_clear) else $error("coulomb not cleared");

  property p_arith_clear;
    @(posedge clock) disable iff (rst)
      ((conversion_start || accumulator_clear) && !arith_overflow) |=> !arith_overflow_flag_q;
  endproperty
  a_arith_clear: assert property (p_arith_clear) else $error("arith flag not cleared");

  property p_done_start;
    @(posedge clock) disable iff (rst)
      (conversion_start && !conversion_done) |=> !conversion_done_flag_q;
  endproperty
  a_done_start: assert property (p_done_start) else $error("done kept over start");

  property p_temp_over;
    @(posedge clock) disable iff (rst)
      (result_valid && $signed(temp_reading) > $signed(temp_limit)) |=> limit_flags_q[5];
  endproperty
  a_temp_over: assert property (p_temp_over) else $error("temp over missed");

  property p_shunt_under;
    @(posedge clock) disable iff (rst)
      (result_valid && $signed(shunt_reading[19:4]) < $signed(shunt_under_threshold_q))
        |=> limit_flags_q[3];
  endproperty
  a_shunt_under: assert property (p_shunt_under) else $error("shunt under missed");

  property p_bus_over;
    @(posedge clock) disable iff (rst)
      (result_valid && bus_reading[19:4] > {1'b0, bus_over_threshold_q}) |=> limit_flags_q[2];
  endproperty
  a_bus_over: assert property (p_bus_over) else $error("bus over missed");

  property p_bus_under;
    @(posedge clock) disable iff (rst)
      (result_valid && bus_reading[19:4] < {1'b0, bus_under_threshold}) |=> limit_flags_q[1];
  endproperty
  a_bus_under: assert property (p_bus_under) else $error("bus under missed");

  property p_power_over;
    @(posedge clock) disable iff (rst)
      (result_valid && power_reading[23:8] > power_limit) |=> limit_flags_q[0];
  endproperty
  a_power_over: assert property (p_power_over) else $error("power over missed");

  property p_limit_clear;
    @(posedge clock) disable iff (rst)
      (alert_latch_select_q && diag_read && !result_valid) |=> (limit_flags_q == 6'h00);
  endproperty
  a_limit_clear: assert property (p_limit_clear) else $error("limit flags not cleared");

  property p_checksum_ok;
    @(posedge clock) disable iff (rst)
      !checksum_fail |=> trim_checksum_ok_q;
  endproperty
  a_checksum_ok: assert property (p_checksum_ok) else $error("checksum status low");
endmodule

// File: bench/limit_compare_diag_flags_tb_top.sv
/*
  Self-checking bench for the limit compare and diagnostic flag block.
  Assumes the word-strobe register port and event pulses of the block.
*/
`timescale 1ns/1ps
module limit_compare_diag_flags_tb_top;
  logic        clock;
  logic        rst;
  logic [5:0]  reg_index;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata_q;
  logic        result_valid;
  logic [19:0] shunt_reading;
  logic [19:0] bus_reading;
  logic [15:0] temp_reading;
  logic [23:0] power_reading;
  logic [5:0]  ev;
  logic        checksum_fail;
  logic        alert_latch_select_q;
  logic        coulomb_overflow_flag_q;
  logic        arith_overflow_flag_q;
  logic        conversion_done_flag_q;
  logic        trim_checksum_ok_q;
  logic [5:0]  limit_flags_q;
  int          fail_count;
  int          comparisons;
  // one row per limit flag, last row sits exactly on every over threshold
  logic [19:0] sh_tab [7] = '{20'h0, 20'h10010, 20'hefff0, 20'h0, 20'h0, 20'h0, 20'h1000f};
  logic [19:0] bu_tab [7] = '{20'h08000, 20'h08000, 20'h08000, 20'h10010, 20'h0, 20'h08000,
                              20'h1000f};
  logic [15:0] te_tab [7] = '{16'h1001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1000};
  logic [23:0] pw_tab [7] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h100100, 24'h1000ff};
  logic [5:0]  ex_tab [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};

  limit_compare_diag_flags u_dut
  (
    .clock                   (clock),
    .rst                     (rst),
    .reg_index               (reg_index),
    .reg_write               (reg_write),
    .reg_read                (reg_read),
    .reg_wdata               (reg_wdata),
    .reg_rdata_q             (reg_rdata_q),
    .result_valid            (result_valid),
    .shunt_reading           (shunt_reading),
    .bus_reading             (bus_reading),
    .temp_reading            (temp_reading),
    .power_reading           (power_reading),
    .temp_limit              (16'h1000),
    .power_limit             (16'h1000),
    .bus_under_threshold     (15'h0100),
    .input_range_select      (1'b0),
    .conversion_done         (ev[0]),
    .conversion_start        (ev[1]),
    .arith_overflow          (ev[2]),
    .coulomb_wrap            (ev[3]),
    .charge_read             (ev[4]),
    .accumulator_clear       (ev[5]),
    .checksum_fail           (checksum_fail),
    .alert_latch_select_q    (alert_latch_select_q),
    .coulomb_overflow_flag_q (coulomb_overflow_flag_q),
    .arith_overflow_flag_q   (arith_overflow_flag_q),
    .conversion_done_flag_q  (conversion_done_flag_q),
    .trim_checksum_ok_q      (trim_checksum_ok_q),
    .limit_flags_q           (limit_flags_q)
  );

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [5:0] idx, input logic [15:0] d);
    @(posedge clock) #1;
    reg_index = idx;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clock) #1;
    reg_write = 1'b0;
  endtask

  // read data is sampled 1 ns after the edge that takes the read strobe
  task rd(input string what, input logic [5:0] idx, input logic [15:0] exp);
    @(posedge clock) #1;
    reg_index = idx;
    reg_read  = 1'b1;
    @(posedge clock) #1;
    reg_read  = 1'b0;
    check(what, reg_rdata_q, exp);
  endtask

  task pulse(input int which);
    @(posedge clock) #1;
    ev = 6'h01 << which;
    @(posedge clock) #1;
    ev = 6'h00;
  endtask

  task result(input int i);
    @(posedge clock) #1;
    shunt_reading = sh_tab[i];
    bus_reading   = bu_tab[i];
    temp_reading  = te_tab[i];
    power_reading = pw_tab[i];
    result_valid  = 1'b1;
    @(posedge clock) #1;
    result_valid  = 1'b0;
  endtask

  task results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    fail_count++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {reg_index, reg_write, reg_read, reg_wdata, result_valid} = '0;
    {shunt_reading, bus_reading, temp_reading, power_reading, ev, checksum_fail} = '0;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    // reset values and unmapped index
    rd("shunt over reset", 6'h0c, 16'h7fff);
    rd("shunt under reset", 6'h0d, 16'h8000);
    rd("bus over reset", 6'h0e, 16'h7fff);
    rd("diag reset", 6'h0b, 16'h0001);
    wr(6'h20, 16'h1234);
    rd("unmapped", 6'h20, 16'h0000);
    wr(6'h0e, 16'hffff);
    rd("bus over top bit", 6'h0e, 16'h7fff);
    wr(6'h0c, 16'h1000);
    wr(6'h0d, 16'hf000);
    wr(6'h0e, 16'h1000);
    rd("shunt under write", 6'h0d, 16'hf000);
    $display("test registers done");
    // transparent flags follow each result, equal values do not trip
    for (int i = 0; i < 7; i++)
    begin
      result(i);
      check("limit flags", 16'(limit_flags_q), 16'(ex_tab[i]));
    end
    // negative over threshold trips at zero volts
    // over threshold kept above the under threshold
    wr(6'h0c, 16'hfff0);
    result(4);
    check("shunt over at zero", 16'(limit_flags_q), 16'h0012);
    result(0);
    check("shunt over signed", 16'(limit_flags_q), 16'h0030);
    wr(6'h0c, 16'h1000);
    result(6);
    check("flags back to idle", 16'(limit_flags_q), 16'h0000);
    $display("test transparent done");
    // latched mode: only bit 15 of a diag write is stored
    wr(6'h0b, 16'hffff);
    check("latch select", 16'(alert_latch_select_q), 16'h0001);
    rd("diag latch only", 6'h0b, 16'h8001);
    result(0);
    pulse(0);
    result(6);
    check("latched hold", 16'(limit_flags_q), 16'h0020);
    rd("diag latched", 6'h0b, 16'h8083);
    check("read clears limits", 16'(limit_flags_q), 16'h0000);
    check("read clears done", 16'(conversion_done_flag_q), 16'h0000);
    pulse(0);
    pulse(1);
    check("start clears done", 16'(conversion_done_flag_q), 16'h0000);
    $display("test latched done");
    // overflow flags and their clearing events
    pulse(2);
    result(6);
    check("arith held", 16'(arith_overflow_flag_q), 16'h0001);
    pulse(1);
    check("arith start clear", 16'(arith_overflow_flag_q), 16'h0000);
    pulse(2);
    pulse(5);
    check("arith acc clear", 16'(arith_overflow_flag_q), 16'h0000);
    pulse(3);
    rd("diag coulomb", 6'h0b, 16'h8401);
    check("coulomb after diag", 16'(coulomb_overflow_flag_q), 16'h0001);
    pulse(4);
    check("coulomb cleared", 16'(coulomb_overflow_flag_q), 16'h0000);
    $display("test overflow done");
    // trim checksum status follows the failure level
    checksum_fail = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rd("diag checksum", 6'h0b, 16'h8000);
    checksum_fail = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("checksum ok", 16'(trim_checksum_ok_q), 16'h0001);
    $display("test checksum done");
    results();
  end
endmodule
